/* hw/urx_top.sv */
// urx_top: uart receiver with fifo, error flags and merged interrupt
// assumes: baud tick at 16x rate from an outside generator, rx pin async
`timescale 1ns/100ps
module urx_top #(
  parameter int DEPTH = 4
) (
  input  wire logic        CLK_SYS,
  input  wire logic        RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        RX_PIN,
  input  wire logic        SAMPLE_TICK,
  input  wire logic        UART_CLOCK_STOPPED,
  input  wire logic        TX_BUF_EMPTY,
  input  wire logic        TX_IDLE,
  output logic             UART_IRQ_N
);
  import urx_pkg::*;

  // ----------------------------------------
  // bus and registers
  // ----------------------------------------
  logic [7:0]  ctrl_one_r;
  logic [7:0]  ctrl_two_r;
  logic        wr_acc;
  logic        rd_acc;
  logic        acc;
  logic        status_seen_r;
  logic [31:0] prdata_r;

  assign acc     = PSEL & PENABLE;
  assign wr_acc  = acc & PWRITE;
  assign rd_acc  = acc & ~PWRITE;
  assign PREADY  = 1'b1;
  assign PSLVERR = acc & ~(PADDR == ADDR_CTRL_ONE || PADDR == ADDR_CTRL_TWO ||
                           PADDR == ADDR_STATUS || PADDR == ADDR_DATA ||
                           PADDR == ADDR_COUNT);

  logic uart_en, word9, par_en, two_stop, rx_en, addr_det, wake_en, rx_ie;
  logic [1:0] par_type;
  logic [2:0] trig_lvl;
  assign uart_en  = ctrl_one_r[CO_UART_EN];
  assign word9    = ctrl_one_r[CO_WORD_LEN];
  assign par_en   = ctrl_one_r[CO_PAR_EN];
  assign par_type = ctrl_one_r[CO_PAR_TYPE +: 2];
  assign two_stop = ctrl_one_r[CO_STOP_BITS];
  assign rx_en    = ctrl_two_r[CT_RX_EN];
  assign addr_det = ctrl_two_r[CT_ADDR_DET];
  assign wake_en  = ctrl_two_r[CT_WAKE];
  assign rx_ie    = ctrl_two_r[CT_RX_IRQ];
  // trigger level 1..4 coded as field+1
  assign trig_lvl = {1'b0, ctrl_two_r[CT_TRIG +: 2]} + 3'h1;

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ctrl_one_r <= CTRL_ONE_RST;
      ctrl_two_r <= CTRL_TWO_RST;
    end else if (wr_acc) begin
      if (PADDR == ADDR_CTRL_ONE) ctrl_one_r <= PWDATA[7:0];
      if (PADDR == ADDR_CTRL_TWO) ctrl_two_r <= PWDATA[7:0];
    end
  end

  // ----------------------------------------
  // rx pin synchroniser and 3-sample vote
  // ----------------------------------------
  logic rx_s1_r, rx_s2_r, rx_s3_r;
  logic [2:0] smp_r;
  logic [3:0] os_cnt_r;
  logic       vote;
  logic       noisy;
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
      rx_s3_r <= 1'b1;
    end else begin
      rx_s1_r <= RX_PIN;
      rx_s2_r <= rx_s1_r;
      rx_s3_r <= rx_s2_r;
    end
  end

  // samples at oversample slots 7, 8, 9 around the bit centre
  always_ff @(posedge CLK_SYS) begin
    if (RST) smp_r <= 3'h7;
    else if (SAMPLE_TICK && os_cnt_r >= 4'h7 && os_cnt_r <= 4'h9)
      smp_r <= {smp_r[1:0], rx_s2_r};
  end
  assign vote  = (smp_r[0] & smp_r[1]) | (smp_r[1] & smp_r[2]) | (smp_r[0] & smp_r[2]);
  assign noisy = ~((smp_r == 3'h0) | (smp_r == 3'h7));

  // ----------------------------------------
  // receive state machine
  // ----------------------------------------
  urx_state_type state_r;
  logic [8:0] shift_r;
  logic [3:0] bit_cnt_r;
  logic       noise_acc_r;
  logic       stop_seen_r;
  logic       stop_two_r;
  logic       bit_end;
  logic       word_done;
  logic       word_framing_error_flag;
  logic       word_parity_error_flag;
  logic [3:0] nbits;
  logic       par_calc;
  logic       par_exp;

  assign nbits   = word9 ? 4'h9 : 4'h8;
  assign bit_end = SAMPLE_TICK && (os_cnt_r == 4'(OVERSAMPLE - 1));
  assign par_calc = word9 ? ^shift_r : ^shift_r[8:1];
  always_comb begin
    case (par_type)
      PAR_EVEN:  par_exp = par_calc;
      PAR_ODD:   par_exp = ~par_calc;
      PAR_MARK:  par_exp = 1'b1;
      default:   par_exp = 1'b0;
    endcase
  end

  logic parity_error_flag_r;
  always_ff @(posedge CLK_SYS) begin
    if (RST || !uart_en) begin
      state_r     <= S_IDLE;
      os_cnt_r    <= 4'h0;
      bit_cnt_r   <= 4'h0;
      shift_r     <= 9'h000;
      noise_acc_r <= 1'b0;
      parity_error_flag_r      <= 1'b0;
      stop_seen_r <= 1'b0;
      stop_two_r  <= 1'b0;
    end else begin
      stop_seen_r <= 1'b0;
      case (state_r)
        S_IDLE: begin
          os_cnt_r <= 4'h0;
          if (rx_en && !rx_s3_r) begin
            state_r     <= S_START;
            noise_acc_r <= 1'b0;
            parity_error_flag_r      <= 1'b0;
            bit_cnt_r   <= 4'h0;
            stop_two_r  <= 1'b0;
          end
        end
        S_START: begin
          if (SAMPLE_TICK) os_cnt_r <= os_cnt_r + 4'h1;
          if (bit_end) begin
            if (vote) state_r <= S_IDLE;
            else      state_r <= S_DATA;
            noise_acc_r <= noisy;
          end
        end
        S_DATA: begin
          if (SAMPLE_TICK) os_cnt_r <= os_cnt_r + 4'h1;
          if (bit_end) begin
            // lsb first: shift from the top and align at the end
            shift_r     <= {vote, shift_r[8:1]};
            noise_acc_r <= noise_acc_r | noisy;
            bit_cnt_r   <= bit_cnt_r + 4'h1;
            if (bit_cnt_r == nbits - 4'h1)
              state_r <= par_en ? S_PAR : S_STOP;
          end
        end
        S_PAR: begin
          if (SAMPLE_TICK) os_cnt_r <= os_cnt_r + 4'h1;
          if (bit_end) begin
            parity_error_flag_r      <= (vote != par_exp);
            noise_acc_r <= noise_acc_r | noisy;
            state_r     <= S_STOP;
          end
        end
        S_STOP: begin
          if (SAMPLE_TICK) os_cnt_r <= os_cnt_r + 4'h1;
          if (bit_end) begin
            noise_acc_r <= noise_acc_r | noisy;
            if (two_stop && !stop_two_r && vote) begin
              // first of two stop bits was high: the second must be high too
              stop_two_r <= 1'b1;
            end else begin
              stop_seen_r <= 1'b1;
              // a low stop bit never starts a frame; wait for high
              state_r     <= vote ? S_IDLE : S_BRKWAIT;
            end
          end
        end
        S_BRKWAIT: begin
          if (rx_s3_r) state_r <= S_IDLE;
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // frame ends at the last configured stop bit; a low one ends it at once
  assign word_done = stop_seen_r;
  assign word_framing_error_flag = (state_r == S_BRKWAIT);
  assign word_parity_error_flag = parity_error_flag_r;

  // assembled word aligned to the configured length; break gives zeros
  logic [8:0] word_data;
  assign word_data = word9 ? shift_r : {1'b0, shift_r[8:1]};

  // ----------------------------------------
  // fifo and flags
  // ----------------------------------------
  urx_word_type mem [DEPTH];
  logic [1:0] wp_r, rp_r;
  logic [2:0] cnt_r;
  logic       full, empty, pop, push;
  logic       overrun_flag_r, rx_idle_flag_r;
  logic       overrun_ev;

  assign full  = (cnt_r == 3'(DEPTH));
  assign empty = (cnt_r == 3'h0);
  assign pop   = rd_acc && (PADDR == ADDR_DATA) && status_seen_r && !empty;
  assign push  = word_done && !full;
  assign overrun_ev = word_done && full;

  always_ff @(posedge CLK_SYS) begin
    if (push) mem[wp_r] <= '{data: word_data, noise: noise_acc_r,
                             framing_error_flag: word_framing_error_flag, parity_error_flag: word_parity_error_flag};
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST || !uart_en) begin
      wp_r  <= 2'h0;
      rp_r  <= 2'h0;
      cnt_r <= 3'h0;
    end else begin
      if (push) wp_r <= wp_r + 2'h1;
      if (pop)  rp_r <= rp_r + 2'h1;
      cnt_r <= cnt_r + 3'(push) - 3'(pop);
    end
  end

  // overrun: set wins over clear
  always_ff @(posedge CLK_SYS) begin
    if (RST || !uart_en) overrun_flag_r <= 1'b0;
    else if (overrun_ev) overrun_flag_r <= 1'b1;
    else if (pop)        overrun_flag_r <= 1'b0;
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST || !uart_en) rx_idle_flag_r <= 1'b1;
    else if (state_r == S_IDLE && rx_en && !rx_s3_r) rx_idle_flag_r <= 1'b0;
    else if (stop_seen_r) rx_idle_flag_r <= 1'b1;
  end

  // clearing sequence step one: a status read arms the data read
  always_ff @(posedge CLK_SYS) begin
    if (RST || !uart_en) status_seen_r <= 1'b0;
    else if (rd_acc && PADDR == ADDR_STATUS) status_seen_r <= 1'b1;
    else if (pop) status_seen_r <= 1'b0;
  end

  urx_word_type head;
  assign head = empty ? '0 : mem[rp_r];
  logic [7:0] status;
  always_comb begin
    status = 8'h00;
    status[ST_PARITY_ERROR_FLAG]  = head.parity_error_flag;
    status[ST_NOISE] = head.noise;
    status[ST_FRAMING_ERROR_FLAG]  = head.framing_error_flag;
    status[ST_OVERRUN_FLAG]  = overrun_flag_r;
    status[ST_RX_IDLE_FLAG] = rx_idle_flag_r;
    status[ST_RXAV]  = !empty;
    status[ST_RX9]   = head.data[8];
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) prdata_r <= 32'h0000_0000;
    else if (PSEL && !PENABLE && !PWRITE) begin
      case (PADDR)
        ADDR_CTRL_ONE: prdata_r <= {24'h000000, ctrl_one_r};
        ADDR_CTRL_TWO: prdata_r <= {24'h000000, ctrl_two_r};
        ADDR_STATUS:   prdata_r <= {24'h000000, status};
        ADDR_DATA:     prdata_r <= {24'h000000, head.data[7:0]};
        ADDR_COUNT:    prdata_r <= {29'h00000000, cnt_r};
        default:       prdata_r <= 32'h0000_0000;
      endcase
    end
  end
  assign PRDATA = prdata_r;

  // ----------------------------------------
  // interrupt merge
  // ----------------------------------------
  logic rx_trig_ev, addr_ok, wake_ev, irq_ev, irq_n_r;
  logic rx_s3_d_r;
  always_ff @(posedge CLK_SYS) begin
    if (RST) rx_s3_d_r <= 1'b1;
    else     rx_s3_d_r <= rx_s3_r;
  end
  // top received bit gates the data-available interrupt in address mode
  assign addr_ok    = !addr_det || (word9 ? word_data[8] : word_data[7]);
  assign rx_trig_ev = push && (cnt_r + 3'h1 == trig_lvl) && addr_ok;
  // wake runs only while the uart clock is reported stopped
  assign wake_ev    = UART_CLOCK_STOPPED && wake_en && rx_ie && uart_en && rx_en &&
                      rx_s3_d_r && !rx_s3_r;
  assign irq_ev = (rx_ie && (rx_trig_ev || overrun_ev)) || wake_ev ||
                  (ctrl_two_r[CT_TXE_IRQ] && TX_BUF_EMPTY) ||
                  (ctrl_two_r[CT_TXI_IRQ] && TX_IDLE);

  always_ff @(posedge CLK_SYS) begin
    if (RST) irq_n_r <= 1'b1;
    else     irq_n_r <= !irq_ev;
  end
  assign UART_IRQ_N = irq_n_r;
endmodule

/* hw/urx_pkg.sv */
// urx_pkg: constants, types and register map of the uart receive block
// assumes: one 125 MHz clock, apb slave with 32-bit data
package urx_pkg;
  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTRL_ONE = 8'h00;
  localparam logic [7:0] ADDR_CTRL_TWO = 8'h04;
  localparam logic [7:0] ADDR_STATUS   = 8'h08;
  localparam logic [7:0] ADDR_DATA     = 8'h0C;
  localparam logic [7:0] ADDR_COUNT    = 8'h10;
  // ctrl one fields
  localparam int CO_UART_EN   = 7;
  localparam int CO_WORD_LEN  = 6;
  localparam int CO_PAR_EN    = 5;
  localparam int CO_PAR_TYPE  = 3;
  localparam int CO_STOP_BITS = 2;
  // ctrl two fields
  localparam int CT_RX_EN     = 7;
  localparam int CT_ADDR_DET  = 6;
  localparam int CT_WAKE      = 5;
  localparam int CT_RX_IRQ    = 4;
  localparam int CT_TXE_IRQ   = 3;
  localparam int CT_TXI_IRQ   = 2;
  localparam int CT_TRIG      = 0;
  // status fields
  localparam int ST_PARITY_ERROR_FLAG  = 0;
  localparam int ST_NOISE = 1;
  localparam int ST_FRAMING_ERROR_FLAG  = 2;
  localparam int ST_OVERRUN_FLAG  = 3;
  localparam int ST_RX_IDLE_FLAG = 4;
  localparam int ST_RXAV  = 5;
  localparam int ST_RX9   = 6;
  localparam logic [7:0] CTRL_ONE_RST = 8'h00;
  localparam logic [7:0] CTRL_TWO_RST = 8'h00;
  localparam int OVERSAMPLE  = 16;
  localparam int FIFO_DEPTH  = 4;
  localparam int IRQ_PULSE_CYC = 1;
  // parity types
  localparam logic [1:0] PAR_EVEN  = 2'h0;
  localparam logic [1:0] PAR_ODD   = 2'h1;
  localparam logic [1:0] PAR_MARK  = 2'h2;
  localparam logic [1:0] PAR_SPACE = 2'h3;

  typedef enum {S_IDLE, S_START, S_DATA, S_PAR, S_STOP, S_BRKWAIT} urx_state_type;

  typedef struct packed {
    logic       paddr_ok;
    logic [7:0] paddr;
    logic       pwrite;
    logic [31:0] pwdata;
  } urx_apb_req_type;

  typedef struct packed {
    logic [8:0] data;
    logic       noise;
    logic       framing_error_flag;
    logic       parity_error_flag;
  } urx_word_type;
endpackage

/* tb/urx_line_model.sv */
// urx_line_model: remote serial transmitter driving the receive line
// assumes: SAMPLE_TICK pulses once per 16th of a bit in the CLK_SYS domain
`timescale 1ns/100ps
module urx_line_model (
  input  wire logic CLK_SYS,
  input  wire logic SAMPLE_TICK,
  output logic      RX_PIN
);
  // raised when no tick came within the bound; the bench counts it
  logic stuck = 1'b0;
  initial RX_PIN = 1'b1;
  task tk;
    int i;
    i = 0;
    do begin
      @(posedge CLK_SYS);
      i++;
    end while (SAMPLE_TICK !== 1'b1 && i < 64);
    if (SAMPLE_TICK !== 1'b1) stuck = 1'b1;
  endtask
  // sixteen ticks a bit; g inverts one mid-bit tick so only one vote disagrees
  task bitt(input logic v, input logic g);
    for (int k = 0; k < 16; k++) begin
      RX_PIN <= (g && k == 8) ? ~v : v;
      tk();
    end
  endtask
  task send(input logic [8:0] d, input int nb, input logic pe, input logic pv,
            input logic sv, input logic nz);
    bitt(1'b0, 1'b0);
    for (int i = 0; i < nb; i++) bitt(d[i], nz && i == 3);
    if (pe) bitt(pv, 1'b0);
    bitt(sv, 1'b0);
    bitt(1'b1, 1'b0);
  endtask
  task brk(input int n);
    repeat (n) bitt(1'b0, 1'b0);
    bitt(1'b1, 1'b0);
  endtask
endmodule

/* tb/urx_chk.sv */
// urx_chk: port-level assertions for the uart receive block
// assumes: bound into urx_top; one clock, synchronous active-high reset
`timescale 1ns/100ps
module urx_chk
  import urx_pkg::*;
#(
  parameter int DEPTH = 4
) (
  input wire logic        CLK_SYS,
  input wire logic        RST,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        RX_PIN,
  input wire logic        SAMPLE_TICK,
  input wire logic        UART_CLOCK_STOPPED,
  input wire logic        TX_BUF_EMPTY,
  input wire logic        TX_IDLE,
  input wire logic        UART_IRQ_N
);
  logic [7:0] c1_r;
  logic [7:0] c2_r;
  logic       mapped;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  assign mapped = PADDR inside {ADDR_CTRL_ONE, ADDR_CTRL_TWO, ADDR_STATUS, ADDR_DATA, ADDR_COUNT};
  // mirror of control writes, so interrupt checks know which sources are enabled
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      c1_r <= 8'h00;
      c2_r <= 8'h00;
    end else if (PSEL && PENABLE && PWRITE && PREADY) begin
      if (PADDR == ADDR_CTRL_ONE) c1_r <= PWDATA[7:0];
      if (PADDR == ADDR_CTRL_TWO) c2_r <= PWDATA[7:0];
    end
  end
  sequence bad_s;
    PSEL && PENABLE && !mapped;
  endsequence
  sequence cnt_s;
    PSEL && PENABLE && !PWRITE && PADDR == ADDR_COUNT;
  endsequence
  sequence fall_s;
    $fell(RX_PIN) && UART_CLOCK_STOPPED && c1_r[7] && c2_r[7] && c2_r[5:4] == 2'h3;
  endsequence
  ready_high_a: assert property (PREADY)
    else $error("pready low");
  unmapped_a: assert property (bad_s |-> PSLVERR && (PWRITE || PRDATA == 32'h0))
    else $error("unmapped access not refused");
  count_bound_a: assert property (cnt_s |-> PRDATA <= DEPTH)
    else $error("word count above depth");
  irq_reset_a: assert property (disable iff (1'b0) RST |=> UART_IRQ_N)
    else $error("irq low after reset");
  irq_masked_a: assert property (c2_r[6:2] == 5'h00 && $past(c2_r[6:2]) == 5'h00
    && $past(c2_r[6:2], 2) == 5'h00 |-> UART_IRQ_N) else $error("masked irq seen");
  txe_irq_a: assert property ($rose(TX_BUF_EMPTY) && c2_r[3] |-> ##[1:3] !UART_IRQ_N)
    else $error("tx empty irq missing");
  txi_irq_a: assert property ($rose(TX_IDLE) && c2_r[2] |-> ##[1:3] !UART_IRQ_N)
    else $error("tx idle irq missing");
  wake_irq_a: assert property (fall_s |-> ##[1:6] !UART_IRQ_N)
    else $error("wake irq missing");
endmodule
bind urx_top urx_chk #(.DEPTH(DEPTH)) chk_i (.CLK_SYS(CLK_SYS), .RST(RST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .RX_PIN(RX_PIN), .SAMPLE_TICK(SAMPLE_TICK),
  .UART_CLOCK_STOPPED(UART_CLOCK_STOPPED), .TX_BUF_EMPTY(TX_BUF_EMPTY),
  .TX_IDLE(TX_IDLE), .UART_IRQ_N(UART_IRQ_N));

/* tb/tb_top.sv */
// tb_top: directed apb bench for the uart receive block
// assumes: urx_top, urx_line_model and the bound checker are compiled first
`timescale 1ns/100ps
module tb_top;
  import urx_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rx_line;
  logic        tick = 1'b0;
  logic        stopped = 1'b0;
  logic        tx_empty = 1'b0;
  logic        tx_idle = 1'b0;
  logic        irq_n;
  logic [31:0] rv;
  logic        ev;
  logic        pb;
  int          n_errors = 0;
  int          compares = 0;
  int          irq_cnt = 0;
  int          base;
  always #4 clk = ~clk;
  always @(posedge clk) tick <= ~tick & ~rst;
  // count low cycles rather than clearing, so the bench never races the counter
  always @(posedge clk) if (irq_n === 1'b0) irq_cnt <= irq_cnt + 1;
  urx_top #(.DEPTH(FIFO_DEPTH)) uut (.CLK_SYS(clk), .RST(rst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .RX_PIN(rx_line), .SAMPLE_TICK(tick),
    .UART_CLOCK_STOPPED(stopped), .TX_BUF_EMPTY(tx_empty), .TX_IDLE(tx_idle),
    .UART_IRQ_N(irq_n));
  urx_line_model tx (.CLK_SYS(clk), .SAMPLE_TICK(tick), .RX_PIN(rx_line));
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task finish_test;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    chk("pready", pready, 1'b1);
    if (pready !== 1'b1) finish_test();
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task wait_cnt(input int n);
    int i;
    i = 0;
    do begin
      apb(1'b0, ADDR_COUNT, 32'h0);
      i++;
    end while (rv !== n && i < 400);
    chk("count", rv, n);
    if (rv !== n) finish_test();
  endtask
  task pop(input logic [7:0] st, input logic [7:0] d);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status", rv, {24'h0, st});
    apb(1'b0, ADDR_DATA, 32'h0);
    chk("data", rv, {24'h0, d});
  endtask
  task s8(input logic [7:0] d, input int n);
    tx.send({1'b0, d}, 8, 1'b0, 1'b0, 1'b1, 1'b0);
    wait_cnt(n);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, ADDR_CTRL_TWO, 32'h0);
    chk("ctrl_two reset", rv, {24'h0, CTRL_TWO_RST});
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped err", ev, 1'b1);
    chk("unmapped data", rv, 32'h0);
    apb(1'b1, ADDR_CTRL_ONE, 32'h80);
    apb(1'b1, ADDR_CTRL_TWO, 32'h80);
    s8(8'hA5, 1);
    apb(1'b0, ADDR_DATA, 32'h0);
    wait_cnt(1);
    pop(8'h30, 8'hA5);
    apb(1'b1, ADDR_CTRL_TWO, 32'h93);
    base = irq_cnt;
    for (int i = 1; i <= 5; i++) begin
      s8(8'(i), (i < 5) ? i : 4);
      chk("irq trig four", irq_cnt - base, (i < 4) ? 0 : (i - 3) * IRQ_PULSE_CYC);
    end
    pop(8'h38, 8'h01);
    for (int i = 2; i <= 4; i++) pop(8'h30, 8'(i));
    fork
      tx.send(9'h05A, 8, 1'b0, 1'b0, 1'b1, 1'b1);
      begin
        repeat (100) @(posedge clk);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk("idle in frame", rv, 32'h0);
      end
    join
    wait_cnt(1);
    pop(8'h32, 8'h5A);
    tx.send(9'h03C, 8, 1'b0, 1'b0, 1'b0, 1'b0);
    wait_cnt(1);
    pop(8'h34, 8'h3C);
    apb(1'b1, ADDR_CTRL_ONE, 32'h84);
    s8(8'h55, 1);
    pop(8'h30, 8'h55);
    tx.bitt(1'b0, 1'b0);
    repeat (9) tx.bitt(1'b1, 1'b0);
    tx.bitt(1'b0, 1'b0);
    tx.bitt(1'b1, 1'b0);
    wait_cnt(1);
    pop(8'h34, 8'hFF);
    apb(1'b1, ADDR_CTRL_ONE, 32'h80);
    tx.brk(14);
    s8(8'h81, 2);
    pop(8'h34, 8'h00);
    pop(8'h30, 8'h81);
    for (int t = 0; t < 4; t++) begin
      apb(1'b1, ADDR_CTRL_ONE, 32'hA0 | (t << 3));
      pb = (t == PAR_EVEN) ? ^8'h6B : (t == PAR_ODD) ? ~^8'h6B : (t == PAR_MARK);
      for (int k = 0; k < 2; k++) begin
        tx.send(9'h06B, 8, 1'b1, pb ^ k[0], 1'b1, 1'b0);
        wait_cnt(1);
        pop(8'h30 | 8'(k), 8'h6B);
      end
    end
    apb(1'b1, ADDR_CTRL_ONE, 32'hC0);
    tx.send(9'h1C3, 9, 1'b0, 1'b0, 1'b1, 1'b0);
    wait_cnt(1);
    pop(8'h70, 8'hC3);
    apb(1'b1, ADDR_CTRL_ONE, 32'h80);
    apb(1'b1, ADDR_CTRL_TWO, 32'h91);
    base = irq_cnt;
    s8(8'h05, 1);
    chk("irq below trigger", irq_cnt - base, 0);
    s8(8'h06, 2);
    chk("irq at trigger", 32'(irq_cnt != base), 1);
    pop(8'h30, 8'h05);
    pop(8'h30, 8'h06);
    apb(1'b1, ADDR_CTRL_TWO, 32'hD0);
    base = irq_cnt;
    s8(8'h12, 1);
    chk("irq plain word", irq_cnt - base, 0);
    pop(8'h30, 8'h12);
    base = irq_cnt;
    s8(8'h92, 1);
    chk("irq address word", 32'(irq_cnt != base), 1);
    for (int j = 0; j < 2; j++) begin
      apb(1'b1, ADDR_CTRL_TWO, j ? 32'h84 : 32'h88);
      base = irq_cnt;
      tx_empty <= (j == 0);
      tx_idle <= (j == 1);
      repeat (4) @(posedge clk);
      chk("tx irq", 32'(irq_cnt != base), 1);
      tx_empty <= 1'b0;
      tx_idle <= 1'b0;
    end
    apb(1'b1, ADDR_CTRL_TWO, 32'hB0);
    stopped <= 1'b1;
    base = irq_cnt;
    tx.brk(1);
    chk("wake irq", 32'(irq_cnt != base), 1);
    stopped <= 1'b0;
    apb(1'b1, ADDR_CTRL_ONE, 32'h00);
    wait_cnt(0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status off", rv, 32'h10);
    chk("line model tick", tx.stuck, 1'b0);
    finish_test();
  end
endmodule
